// >>> pdc_power_control.sv
// Power-down control register pair and sleep / wake sequencer.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "pdc_consts.svh"
module pdc_power_control (
  input wire logic clock,
  input wire logic resetn,
  input wire pdc_pkg::reg_req_s bus_req,
  output logic [7:0] read_data,
  input wire logic sleep_exec,
  input wire logic wake_irq,
  input wire logic osc_stable,
  input wire logic timebase_selected,
  output var pdc_pkg::power_mode_e mode,
  output var pdc_pkg::clock_gate_s clocks,
  output logic sample_pulse
);
  import pdc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic standby_select;
    logic [2:0] wake_wait_code;
    logic noise_sample_rate_select;
    logic sleep_variant_select;
    logic low_speed_flag;
    logic direct_transfer_flag;
    logic [7:0] rdata;
    power_mode_e mode;
    power_mode_e target;
    logic [17:0] settle_count;
    logic settle_counting;
  } ctrl_state_s;

  ctrl_state_s state_q;
  ctrl_state_s state_d;

  function automatic logic [17:0] wait_states(input logic [2:0] code);
    unique case (code)
      3'h0: wait_states = `PDC_WAIT_0;
      3'h1: wait_states = `PDC_WAIT_1;
      3'h2: wait_states = `PDC_WAIT_2;
      3'h3: wait_states = `PDC_WAIT_3;
      3'h4: wait_states = `PDC_WAIT_4;
      3'h5: wait_states = `PDC_WAIT_5;
      3'h6: wait_states = `PDC_WAIT_6;
      3'h7: wait_states = `PDC_WAIT_7;
    endcase
  endfunction : wait_states

  // Chooses the state a sleep instruction enters from the active modes.
  function automatic power_mode_e sleep_target(input ctrl_state_s s);
    if (s.standby_select) begin
      sleep_target = MODE_STANDBY;
    end else if (s.mode == MODE_SUBACTIVE || s.low_speed_flag) begin
      sleep_target = s.sleep_variant_select ? MODE_SUBSLEEP :
                     MODE_SLEEP;
    end else if (s.direct_transfer_flag && s.sleep_variant_select) begin
      sleep_target = MODE_SUBACTIVE;
    end else begin
      sleep_target = s.sleep_variant_select ? MODE_SUBSLEEP :
                     MODE_SLEEP;
    end
  endfunction : sleep_target

  logic [7:0] ctrl1_image;
  logic [7:0] ctrl2_image;

  always_comb begin
    state_d = state_q;
    ctrl1_image = {state_q.standby_select, state_q.wake_wait_code,
                   state_q.noise_sample_rate_select, 3'h0};
    ctrl2_image = {state_q.sleep_variant_select, state_q.low_speed_flag,
                   state_q.direct_transfer_flag, 5'h00};
    state_d.rdata = 8'h00;
    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    if (bus_req.write) begin
      unique case (bus_req.addr)
        `PDC_ADDR_CTRL1: begin
          state_d.standby_select = bus_req.wdata[`PDC_STBY_BIT];
          state_d.wake_wait_code =
            bus_req.wdata[`PDC_WAIT_HI:`PDC_WAIT_LO];
          state_d.noise_sample_rate_select = bus_req.wdata[`PDC_NOISE_BIT];
        end
        `PDC_ADDR_CTRL2: begin
          state_d.sleep_variant_select = bus_req.wdata[`PDC_SLEEP_VARIANT_SELECT_BIT];
          state_d.low_speed_flag = bus_req.wdata[`PDC_LOW_SPEED_FLAG_BIT];
          state_d.direct_transfer_flag = bus_req.wdata[`PDC_DIRECT_TRANSFER_FLAG_BIT];
        end
        default: begin
        end
      endcase
    end
    if (bus_req.read) begin
      unique case (bus_req.addr)
        `PDC_ADDR_CTRL1: state_d.rdata = ctrl1_image;
        `PDC_ADDR_CTRL2: state_d.rdata = ctrl2_image;
        `PDC_ADDR_STATUS: state_d.rdata = {5'h00, state_q.mode};
        default: state_d.rdata = 8'h00;
      endcase
    end
    // ----------------------------------------------------------------
    // Mode sequencer
    // ----------------------------------------------------------------
    unique case (state_q.mode)
      MODE_ACTIVE, MODE_SUBACTIVE: begin
        if (sleep_exec) begin
          state_d.mode = sleep_target(state_q);
        end
      end
      MODE_SLEEP: begin
        if (wake_irq) begin
          state_d.mode = MODE_ACTIVE;
        end
      end
      MODE_STANDBY, MODE_SUBSLEEP: begin
        if (wake_irq) begin
          state_d.mode = MODE_SETTLE;
          state_d.target = MODE_ACTIVE;
          state_d.settle_count = wait_states(state_q.wake_wait_code);
          state_d.settle_counting = 1'b0;
        end
      end
      MODE_SETTLE: begin
        if (!state_q.settle_counting) begin
          state_d.settle_counting = osc_stable;
        end else if (state_q.settle_count <= 18'd1) begin
          state_d.mode = state_q.target;
          state_d.settle_count = 18'd0;
          state_d.settle_counting = 1'b0;
        end else begin
          state_d.settle_count = state_q.settle_count - 18'd1;
        end
      end
      default: state_d.mode = MODE_ACTIVE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= '0;
      state_q.mode <= MODE_ACTIVE;
      state_q.target <= MODE_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The oscillator runs only when a system-clock mode is live or settling,
  // so the noise sampler idles in subclock and standby modes.
  logic osc_run;
  assign osc_run = (state_q.mode == MODE_ACTIVE) ||
                   (state_q.mode == MODE_SLEEP) ||
                   (state_q.mode == MODE_SETTLE);
  assign read_data = state_q.rdata;
  assign mode = state_q.mode;
  assign clocks.osc_run = osc_run;
  assign clocks.cpu_clock_en = (state_q.mode == MODE_ACTIVE) ||
                               (state_q.mode == MODE_SUBACTIVE);
  assign clocks.periph_clock_en = (state_q.mode != MODE_STANDBY) &&
                                  (state_q.mode != MODE_SETTLE);
  assign clocks.timebase_clock_en = (state_q.mode != MODE_STANDBY) ||
                                    timebase_selected;

  pdc_noise_sampler sampler (
    .clock(clock),
    .resetn(resetn),
    .run(osc_run),
    .fast_select(state_q.noise_sample_rate_select),
    .sample_pulse(sample_pulse)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence standby_sleep_s;
    (mode == MODE_ACTIVE) && sleep_exec && state_q.standby_select;
  endsequence

  standby_entry_a: assert property (@(posedge clock)
    disable iff (!resetn) standby_sleep_s |=> mode == MODE_STANDBY)
    else $error("Sleep with standby select did not enter standby.");

  light_entry_a: assert property (@(posedge clock) disable iff (!resetn)
    ((mode == MODE_ACTIVE) && sleep_exec && !state_q.standby_select &&
     !state_q.sleep_variant_select && !state_q.low_speed_flag)
    |=> mode == MODE_SLEEP)
    else $error("Sleep without standby select left the sleep path.");

  reserved_zero_a: assert property (@(posedge clock)
    disable iff (!resetn)
    (bus_req.read && bus_req.addr == `PDC_ADDR_CTRL1)
    |=> read_data[2:0] == 3'h0)
    else $error("Reserved bits read nonzero.");

  wait_load_a: assert property (@(posedge clock) disable iff (!resetn)
    (mode == MODE_STANDBY && wake_irq && state_q.wake_wait_code == 3'h7)
    |=> state_q.settle_count == 18'd16)
    else $error("Shortest wake code did not load sixteen states.");

  sequence short_wake_s;
    (mode == MODE_STANDBY) && wake_irq && state_q.wake_wait_code == 3'h7
    ##1 osc_stable;
  endsequence

  short_settle_a: assert property (@(posedge clock)
    disable iff (!resetn) short_wake_s |-> ##1 (mode == MODE_SETTLE) [*8]
    ##1 (mode == MODE_SETTLE) [*8] ##1 mode == MODE_ACTIVE)
    else $error("Sixteen-state settle was not honoured.");

  settle_gated_a: assert property (@(posedge clock)
    disable iff (!resetn)
    (mode == MODE_SETTLE) |-> !clocks.cpu_clock_en && !clocks.periph_clock_en)
    else $error("Clocks released before settling finished.");

  standby_halt_a: assert property (@(posedge clock)
    disable iff (!resetn) (mode == MODE_STANDBY) |->
    !clocks.cpu_clock_en && !clocks.periph_clock_en &&
    (clocks.timebase_clock_en == timebase_selected))
    else $error("Standby gating wrong.");

  wait_write_a: assert property (@(posedge clock) disable iff (!resetn)
    (bus_req.write && bus_req.addr == `PDC_ADDR_CTRL1)
    |=> state_q.wake_wait_code == $past(bus_req.wdata[6:4]))
    else $error("Wake wait field not stored.");

endmodule : pdc_power_control
`default_nettype wire

// >>> pdc_consts.svh
// Constants of the power-down control block: offsets, fields, resets, counts.
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PDC_ADDR_CTRL1 4'h0
`define PDC_ADDR_CTRL2 4'h1
`define PDC_ADDR_STATUS 4'h2

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PDC_STBY_BIT 7
`define PDC_WAIT_HI 6
`define PDC_WAIT_LO 4
`define PDC_NOISE_BIT 3
`define PDC_SLEEP_VARIANT_SELECT_BIT 7
`define PDC_LOW_SPEED_FLAG_BIT 6
`define PDC_DIRECT_TRANSFER_FLAG_BIT 5
`define PDC_CTRL1_RESET 8'h00
`define PDC_CTRL2_RESET 8'h00

// ----------------------------------------------------------------
// Timing counts in clock states
// ----------------------------------------------------------------
`define PDC_WAIT_0 18'd8192
`define PDC_WAIT_1 18'd16384
`define PDC_WAIT_2 18'd32768
`define PDC_WAIT_3 18'd65536
`define PDC_WAIT_4 18'd131072
`define PDC_WAIT_5 18'd1024
`define PDC_WAIT_6 18'd128
`define PDC_WAIT_7 18'd16
`define PDC_NOISE_DIV_SLOW 5'd16
`define PDC_NOISE_DIV_FAST 5'd4

`endif

// >>> pdc_pkg.sv
// Types shared by the power-down control block.
`default_nettype none
package pdc_pkg;

  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_SLEEP,
    MODE_SUBACTIVE,
    MODE_SUBSLEEP,
    MODE_STANDBY,
    MODE_SETTLE
  } power_mode_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_req_s;

  typedef struct packed {
    logic cpu_clock_en;
    logic periph_clock_en;
    logic timebase_clock_en;
    logic osc_run;
  } clock_gate_s;

endpackage : pdc_pkg
`default_nettype wire

// >>> pdc_noise_sampler.sv
// Sampling strobe divider that picks the watch-clock sample rate.
`timescale 1ns/10ps
`default_nettype none
`include "pdc_consts.svh"
module pdc_noise_sampler (
  input wire logic clock,
  input wire logic resetn,
  input wire logic run,
  input wire logic fast_select,
  output logic sample_pulse
);
  import pdc_pkg::*;

  typedef struct packed {
    logic [4:0] count;
    logic pulse;
  } sampler_state_s;

  sampler_state_s state_q;
  sampler_state_s state_d;
  logic [4:0] limit;

  always_comb begin
    state_d = state_q;
    limit = fast_select ? `PDC_NOISE_DIV_FAST : `PDC_NOISE_DIV_SLOW;
    state_d.pulse = 1'b0;
    if (!run) begin
      state_d.count = 5'h00;
    end else if (state_q.count >= limit - 5'd1) begin
      state_d.count = 5'h00;
      state_d.pulse = 1'b1;
    end else begin
      state_d.count = state_q.count + 5'd1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sample_pulse = state_q.pulse;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  fast_spacing_a: assert property (@(posedge clock)
    disable iff (!resetn)
    (sample_pulse && fast_select && run) ##1 (fast_select && run) [*3]
    |-> ##1 sample_pulse)
    else $error("Fast sample strobe not every four cycles.");

  slow_gap_a: assert property (@(posedge clock) disable iff (!resetn)
    (sample_pulse && !fast_select) |=> !sample_pulse [*3] ##1
    (!sample_pulse || fast_select))
    else $error("Slow sample strobe came too soon.");

endmodule : pdc_noise_sampler
`default_nettype wire

// >>> power_down_control_one_test.sv
// Self-checking testbench of the power-down control block.
`timescale 1ns/10ps
`default_nettype none
`include "pdc_consts.svh"
module power_down_control_one_test;
  import pdc_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and design
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic resetn = 1'b0;
  reg_req_s bus_req = '0;
  logic [7:0] read_data;
  logic sleep_exec = 1'b0;
  logic wake_irq = 1'b0;
  logic osc_stable = 1'b1;
  logic timebase_selected = 1'b0;
  power_mode_e mode;
  clock_gate_s clocks;
  logic sample_pulse;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] v;

  always #5 clock = ~clock;

  pdc_power_control u_dut (
    .clock(clock),
    .resetn(resetn),
    .bus_req(bus_req),
    .read_data(read_data),
    .sleep_exec(sleep_exec),
    .wake_irq(wake_irq),
    .osc_stable(osc_stable),
    .timebase_selected(timebase_selected),
    .mode(mode),
    .clocks(clocks),
    .sample_pulse(sample_pulse)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("Checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clock);
    bus_req <= '0;
  endtask : wr

  // Read data are sampled mid-cycle, where they stand for one cycle only.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clock);
    bus_req <= '0;
    @(negedge clock);
    d = read_data;
  endtask : rd

  task automatic do_sleep();
    @(posedge clock);
    sleep_exec <= 1'b1;
    @(posedge clock);
    sleep_exec <= 1'b0;
    @(negedge clock);
  endtask : do_sleep

  task automatic do_wake();
    @(posedge clock);
    wake_irq <= 1'b1;
    @(posedge clock);
    wake_irq <= 1'b0;
    @(negedge clock);
  endtask : do_wake

  task automatic settle(input int n);
    chk("mode_settle", mode, MODE_SETTLE);
    repeat (n) @(posedge clock);
    @(negedge clock);
    chk("mode_late", mode, MODE_SETTLE);
    @(negedge clock);
    chk("mode_awake", mode, MODE_ACTIVE);
    chk("cpu_clk", clocks.cpu_clock_en, 1'b1);
    chk("per_clk", clocks.periph_clock_en, 1'b1);
  endtask : settle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    chk("clocks_rst", clocks, 4'hF);
    rd(`PDC_ADDR_CTRL1, v);
    chk("ctrl1_rst", v, `PDC_CTRL1_RESET);
    @(negedge clock);
    chk("rdata_drop", read_data, 8'h00);
    wr(`PDC_ADDR_CTRL1, 8'hFF);
    rd(`PDC_ADDR_CTRL1, v);
    chk("ctrl1_rsvd", v, 8'hF8);
    wr(`PDC_ADDR_CTRL2, 8'hFF);
    rd(`PDC_ADDR_CTRL2, v);
    chk("ctrl2", v, 8'hE0);
    wr(4'hF, 8'h55);
    rd(4'hF, v);
    chk("unmapped", v, 8'h00);
    wr(`PDC_ADDR_STATUS, 8'hFF);
    rd(`PDC_ADDR_STATUS, v);
    chk("status", v, 8'h00);
    wr(`PDC_ADDR_CTRL2, 8'h00);
  endtask : t_regs

  task automatic t_sleep();
    wr(`PDC_ADDR_CTRL1, 8'h70);
    do_sleep();
    chk("to_sleep", mode, MODE_SLEEP);
    do_sleep();
    chk("sleep_again", mode, MODE_SLEEP);
    do_wake();
    chk("sleep_wake", mode, MODE_ACTIVE);
    do_wake();
    chk("stray_wake", mode, MODE_ACTIVE);
  endtask : t_sleep

  task automatic t_standby(input logic tb, input logic [2:0] code,
                           input int n);
    @(posedge clock);
    timebase_selected <= tb;
    wr(`PDC_ADDR_CTRL1, {1'b1, code, 4'h0});
    do_sleep();
    chk("to_standby", mode, MODE_STANDBY);
    chk("stby_cpu", clocks.cpu_clock_en, 1'b0);
    chk("stby_per", clocks.periph_clock_en, 1'b0);
    chk("stby_tb", clocks.timebase_clock_en, tb);
    chk("stby_osc", clocks.osc_run, 1'b0);
    do_wake();
    settle(n);
  endtask : t_standby

  // The count must not start before the oscillator reports stable.
  task automatic t_osc_late();
    int cnt;
    @(posedge clock);
    osc_stable <= 1'b0;
    wr(`PDC_ADDR_CTRL1, 8'hF0);
    do_sleep();
    do_wake();
    repeat (40) @(negedge clock);
    chk("osc_hold", mode, MODE_SETTLE);
    @(posedge clock);
    osc_stable <= 1'b1;
    cnt = 0;
    while (mode !== MODE_ACTIVE && cnt < 40) begin
      @(negedge clock);
      cnt++;
    end
    chk("osc_span", cnt, 18);
  endtask : t_osc_late

  task automatic t_companion();
    wr(`PDC_ADDR_CTRL1, 8'h70);
    wr(`PDC_ADDR_CTRL2, 8'h80);
    do_sleep();
    chk("to_subsleep", mode, MODE_SUBSLEEP);
    do_wake();
    settle(16);
    wr(`PDC_ADDR_CTRL2, 8'hA0);
    do_sleep();
    chk("to_subact", mode, MODE_SUBACTIVE);
    wr(`PDC_ADDR_CTRL2, 8'h80);
    do_sleep();
    chk("sub_sleep", mode, MODE_SUBSLEEP);
    do_wake();
    settle(16);
    wr(`PDC_ADDR_CTRL2, 8'h00);
  endtask : t_companion

  task automatic next_pulse(output int cnt);
    cnt = 0;
    do begin
      @(negedge clock);
      cnt++;
    end while (sample_pulse !== 1'b1 && cnt < 64);
  endtask : next_pulse

  // Two pulses are skipped so a rate change in flight is not measured.
  task automatic t_noise(input logic fast, input int period);
    int cnt;
    wr(`PDC_ADDR_CTRL1, {4'h0, fast, 3'h0});
    next_pulse(cnt);
    next_pulse(cnt);
    next_pulse(cnt);
    chk("sample_period", cnt, period);
  endtask : t_noise

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    t_regs();
    t_sleep();
    t_standby(1'b1, 3'h7, 16);
    t_standby(1'b0, 3'h6, 128);
    t_osc_late();
    t_companion();
    t_noise(1'b0, 16);
    t_noise(1'b1, 4);
    end_sim();
  end

  initial begin
    #100000;
    failures++;
    end_sim();
  end
endmodule : power_down_control_one_test
`default_nettype wire
